// [scss_top.sv]
// system clock source selector with axi4-lite mode register
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - the system clock comes from the fast or slow source as mode bits pick at run time.
// - the same mode bits fix the system clock frequency by dividing the fast source.
// - configuration always names exactly one fast and one slow oscillator.
// - only the four legal source pairings are used; others are coerced to legal ones.
// - the internal fast rc runs at 4, 8 or 12 mhz as configured.
// - the slow source is the internal 32khz rc or the external 32.768khz crystal.
// - the slow source also clocks the watchdog and the time base.
module scss_top
  import scss_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [DATA_W-1:0] rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire scss_cfg_t         cfg_in,
  input  wire logic              ext_fast_crystal_src,
  input  wire logic              ext_rc_fast_src,
  input  wire logic              int_fast_rc_src,
  input  wire logic              ext_slow_crystal_src,
  input  wire logic              int_slow_rc_src,
  output var  logic              sys_clk,
  output var  logic              wdt_clk,
  output var  logic              tb_clk,
  output var  logic [1:0]        int_fast_rc_src_trim,
  output var  logic              osc_pin_a_en,
  output var  logic              osc_pin_b_en
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [SEL_W-1:0] sel_decode(input logic hl, input logic [2:0] cks);
    logic [3:0] d;
    d = CKS_BASE - {1'b0, cks};
    if (hl) begin
      sel_decode = SEL_FAST;
    end else if (cks <= CKS_SLOW_MAX) begin
      sel_decode = SEL_SLOW;
    end else begin
      sel_decode = d[SEL_W-1:0];
    end
  endfunction

  function automatic logic sel_level(input logic [SEL_W-1:0] s, input logic slow,
                                     input logic [DIV_W:0] t);
    if (s == SEL_SLOW) begin
      sel_level = slow;
    end else begin
      sel_level = t[s - SEL_FAST];
    end
  endfunction

  // ------------------------------------------------------------------
  // configuration capture
  // ------------------------------------------------------------------
  scss_cfg_t cfg;
  logic      cfg_locked;
  logic      cfg_fixed;

  // taken once after reset release; straps do not change at run time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg        <= '{hi: HI_INT_RC, lo: LO_INT_RC, freq: FREQ_8MHZ};
      cfg_locked <= 1'h0;
      cfg_fixed  <= 1'h0;
    end else if (!cfg_locked) begin
      cfg_locked <= 1'h1;
      cfg.lo     <= cfg_in.lo;
      cfg.hi     <= (cfg_in.hi == 2'h3) ? HI_INT_RC : cfg_in.hi;
      cfg.freq   <= (cfg_in.freq == 2'h3) ? FREQ_8MHZ : cfg_in.freq;
      cfg_fixed  <= (cfg_in.hi == 2'h3) || (cfg_in.freq == 2'h3);
      // an external slow crystal needs both pins, so any external fast source wins
      if (cfg_in.lo == LO_EXT_XTAL && cfg_in.hi != HI_INT_RC) begin
        cfg.lo    <= LO_INT_RC;
        cfg_fixed <= 1'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // source muxing
  // ------------------------------------------------------------------
  logic           fast_src;
  logic           slow_q;
  logic [DIV_W:0] taps;

  always_comb begin
    case (cfg.hi)
      HI_EXT_XTAL: fast_src = ext_fast_crystal_src;
      HI_EXT_RC:   fast_src = ext_rc_fast_src;
      default:     fast_src = int_fast_rc_src;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_q       <= 1'h0;
      wdt_clk      <= 1'h0;
      tb_clk       <= 1'h0;
      int_fast_rc_src_trim    <= FREQ_8MHZ;
      osc_pin_a_en <= 1'h0;
      osc_pin_b_en <= 1'h0;
    end else begin
      slow_q       <= (cfg.lo == LO_EXT_XTAL) ? ext_slow_crystal_src : int_slow_rc_src;
      wdt_clk      <= slow_q;
      tb_clk       <= slow_q;
      int_fast_rc_src_trim    <= cfg.freq;
      osc_pin_a_en <= (cfg.hi != HI_INT_RC) || (cfg.lo == LO_EXT_XTAL);
      osc_pin_b_en <= (cfg.hi == HI_EXT_XTAL) || (cfg.lo == LO_EXT_XTAL);
    end
  end

  scss_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src     (fast_src),
    .taps    (taps)
  );

  // ------------------------------------------------------------------
  // mode register and glitch-free switch
  // ------------------------------------------------------------------
  logic             mode_hl;
  logic [2:0]       mode_cks;
  logic [SEL_W-1:0] target_sel;
  logic [SEL_W-1:0] cur_sel;
  logic [SEL_W-1:0] next_cur_sel;
  scss_state_t      state;
  scss_state_t      next_state;

  assign target_sel = sel_decode(mode_hl, mode_cks);

  always_comb begin
    next_state   = state;
    next_cur_sel = cur_sel;
    case (state)
      ST_RUN: begin
        // only leave once the output sits low, so no high phase is cut short
        if (target_sel != cur_sel && !sys_clk) begin
          next_state = ST_PARK;
        end
      end
      ST_PARK: begin
        if (!sel_level(target_sel, slow_q, taps)) begin
          next_state   = ST_JOIN;
          next_cur_sel = target_sel;
        end
      end
      ST_JOIN: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_RUN;
      cur_sel <= SEL_FAST;
      sys_clk <= 1'h0;
    end else begin
      state   <= next_state;
      cur_sel <= next_cur_sel;
      // parked output held low until the new source is itself low
      sys_clk <= (next_state == ST_PARK) ? 1'h0
                 : sel_level(next_cur_sel, slow_q, taps);
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              do_write;
  logic [DATA_W-1:0] rd_word;

  assign do_write = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'h1;
      wready  <= 1'h1;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'h0;
        wr_addr <= awaddr;
      end else if (bvalid && bready) begin
        awready <= 1'h1;
      end
      if (wvalid && wready) begin
        wready  <= 1'h0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (bvalid && bready) begin
        wready <= 1'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid   <= 1'h0;
      bresp    <= RESP_OKAY;
      mode_hl  <= MODE_HL_RST;
      mode_cks <= MODE_CKS_RST;
    end else if (do_write) begin
      bvalid <= 1'h1;
      bresp  <= (wr_addr == MODE_OFS) ? RESP_OKAY : RESP_SLVERR;
      if (wr_addr == MODE_OFS && wr_strb[0]) begin
        mode_hl  <= wr_data[MODE_HL_BIT];
        mode_cks <= wr_data[MODE_CKS_LSB +: 3];
      end
    end else if (bvalid && bready) begin
      bvalid <= 1'h0;
    end
  end

  always_comb begin
    rd_word = '0;
    case (araddr)
      MODE_OFS: begin
        rd_word[MODE_HL_BIT]         = mode_hl;
        rd_word[MODE_CKS_LSB +: 3]   = mode_cks;
      end
      STATUS_OFS: begin
        rd_word[STAT_BUSY_BIT]       = (state != ST_RUN) || (cur_sel != target_sel);
        rd_word[STAT_SEL_LSB +: 3]   = cur_sel;
        rd_word[STAT_CLK_BIT]        = sys_clk;
      end
      CONFIG_OFS: begin
        rd_word[CFG_HI_LSB +: 2]     = cfg.hi;
        rd_word[CFG_LO_BIT]          = cfg.lo;
        rd_word[CFG_FREQ_LSB +: 2]   = cfg.freq;
        rd_word[CFG_FIX_BIT]         = cfg_fixed;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h1;
      rvalid  <= 1'h0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'h0;
      rvalid  <= 1'h1;
      rdata   <= rd_word;
      rresp   <= (araddr == MODE_OFS || araddr == STATUS_OFS || araddr == CONFIG_OFS)
                 ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'h0;
      arready <= 1'h1;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  logic prev_level;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_level <= 1'h0;
    end else begin
      prev_level <= sel_level(cur_sel, slow_q, taps);
    end
  end

  // two running edges in a row: the leave-to-park edge forces the output low on purpose
  run_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_RUN ##1 state == ST_RUN |-> sys_clk == prev_level)
    else $error("system clock does not follow the chosen source");

  switch_commit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_PARK && !sel_level(target_sel, slow_q, taps)
    |=> cur_sel == $past(target_sel) && state == ST_JOIN)
    else $error("parked switch did not commit to the new selection");

  cfg_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_locked |-> cfg.hi != 2'h3 && cfg.freq != 2'h3)
    else $error("configuration left without a legal oscillator");

  pair_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_locked && cfg.lo == LO_EXT_XTAL |-> cfg.hi == HI_INT_RC)
    else $error("illegal fast and slow source pairing");

  trim_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_locked ##1 1'b1 |-> int_fast_rc_src_trim == $past(cfg.freq))
    else $error("internal rc trim does not match configuration");

  slow_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_locked ##1 cfg.lo == LO_EXT_XTAL |=> slow_q == $past(ext_slow_crystal_src))
    else $error("slow source not taken from the external crystal");

  aux_clocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 1'b1 |-> wdt_clk == $past(slow_q) && tb_clk == wdt_clk)
    else $error("watchdog or time base clock not fed by the slow source");

  park_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state == ST_PARK) |-> !sys_clk && !$past(sys_clk))
    else $error("system clock high while switching sources");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");

  fast_to_slow_c: cover property (@(posedge aclk) disable iff (!aresetn)
    cur_sel == SEL_FAST ##[1:300] cur_sel == SEL_SLOW);
  slow_to_div_c: cover property (@(posedge aclk) disable iff (!aresetn)
    cur_sel == SEL_SLOW ##[1:300] cur_sel > SEL_FAST);
  park_cycle_c: cover property (@(posedge aclk) disable iff (!aresetn)
    state == ST_RUN ##1 state == ST_PARK ##[1:200] state == ST_JOIN);

endmodule
`default_nettype wire

// [scss_pkg.sv]
// shared constants and types for the system clock source selector
package scss_pkg;

  // ------------------------------------------------------------------
  // clock and bus
  // ------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;

  localparam logic [ADDR_W-1:0] MODE_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h08;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // mode register layout
  // ------------------------------------------------------------------
  localparam int unsigned MODE_HL_BIT  = 0;
  localparam int unsigned MODE_CKS_LSB = 1;
  localparam logic        MODE_HL_RST  = 1'h1;
  localparam logic [2:0]  MODE_CKS_RST = 3'h0;

  // status and config layouts
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_SEL_LSB  = 1;
  localparam int unsigned STAT_CLK_BIT  = 4;
  localparam int unsigned CFG_HI_LSB    = 0;
  localparam int unsigned CFG_LO_BIT    = 2;
  localparam int unsigned CFG_FREQ_LSB  = 3;
  localparam int unsigned CFG_FIX_BIT   = 8;

  // ------------------------------------------------------------------
  // source choices
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    HI_EXT_XTAL = 2'h0,
    HI_EXT_RC   = 2'h1,
    HI_INT_RC   = 2'h2
  } scss_hi_t;

  typedef enum logic {
    LO_INT_RC   = 1'h0,
    LO_EXT_XTAL = 1'h1
  } scss_lo_t;

  typedef enum logic [1:0] {
    FREQ_4MHZ  = 2'h0,
    FREQ_8MHZ  = 2'h1,
    FREQ_12MHZ = 2'h2
  } scss_freq_t;

  typedef struct packed {
    logic [1:0] hi;
    logic       lo;
    logic [1:0] freq;
  } scss_cfg_t;

  // 0 = slow, 1 = fast undivided, 2..7 = fast divided by 2..64
  localparam int unsigned SEL_W     = 3;
  localparam logic [2:0]  SEL_SLOW  = 3'h0;
  localparam logic [2:0]  SEL_FAST  = 3'h1;
  localparam logic [2:0]  CKS_SLOW_MAX = 3'h1;
  localparam logic [3:0]  CKS_BASE  = 4'h9;
  localparam int unsigned DIV_W     = 6;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h0,
    ST_PARK = 2'h1,
    ST_JOIN = 2'h3
  } scss_state_t;

endpackage

// [scss_div.sv]
// ripple of fast-clock taps, divided by powers of two
`timescale 1ns/1ps
`default_nettype none
module scss_div
  import scss_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             src,
  output var  logic [DIV_W:0]   taps
);

  logic             src_q;
  logic [DIV_W-1:0] cnt;

  // ------------------------------------------------------------------
  // count rising edges of the sampled source
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 1'h0;
      cnt   <= '0;
    end else begin
      src_q <= src;
      if (src && !src_q) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  assign taps = {cnt, src};

endmodule
`default_nettype wire

// [scss_top_test.sv]
// self-checking bench for the system clock source selector
`timescale 1ns/1ps
`default_nettype none
module scss_top_test
  import scss_pkg::*;
;
  // ------------------------------------------------------------------
  // signals and tables
  // ------------------------------------------------------------------
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r, int_fast_rc_src_trim;
  logic [1:0]        hist = 2'h0;
  logic              awready, wready, bvalid, arready, rvalid;
  scss_cfg_t         cfg_in;
  logic              ext_fast_crystal_src = 1'b0;
  logic              ext_rc_fast_src      = 1'b0;
  logic              int_fast_rc_src      = 1'b0;
  logic              ext_slow_crystal_src = 1'b0;
  logic              int_slow_rc_src      = 1'b0;
  logic              sys_clk, wdt_clk, tb_clk, osc_pin_a_en, osc_pin_b_en;
  logic              mon, lo_ext, hl;
  logic              last_clk = 1'b0;
  logic [2:0]        cks, esel;
  int                t, m, i, cnt, per, errors, n_checks;
  int                run = 0;
  int unsigned       cyc = 0;
  // last entry: bad fast code with external slow crystal, both get coerced
  logic [4:0]        cfg_tab [5] = '{5'h01, 5'h17, 5'h0e, 5'h10, 5'h1e};
  logic [31:0]       exp_cfg [5] = '{32'h008, 32'h10e, 32'h111, 32'h002, 32'h112};
  int                pf      [5] = '{4, 6, 8, 6, 6};
  int                ps      [5] = '{16, 32, 16, 16, 16};
  logic [1:0]        pins    [5] = '{2'h3, 2'h3, 2'h2, 2'h0, 2'h0};
  logic [1:0]        trim    [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h2};

  scss_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cfg_in(cfg_in), .ext_fast_crystal_src(ext_fast_crystal_src),
    .ext_rc_fast_src(ext_rc_fast_src), .int_fast_rc_src(int_fast_rc_src),
    .ext_slow_crystal_src(ext_slow_crystal_src), .int_slow_rc_src(int_slow_rc_src),
    .sys_clk(sys_clk), .wdt_clk(wdt_clk), .tb_clk(tb_clk), .int_fast_rc_src_trim(int_fast_rc_src_trim),
    .osc_pin_a_en(osc_pin_a_en), .osc_pin_b_en(osc_pin_b_en));

  initial begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  // ------------------------------------------------------------------
  // oscillators and monitors
  // ------------------------------------------------------------------
  // distinct periods so a wrong source shows up as a wrong rate
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ext_fast_crystal_src <= cyc[1];
    ext_rc_fast_src <= cyc[2];
    int_fast_rc_src <= (cyc % 6) < 3;
    ext_slow_crystal_src <= cyc[4];
    int_slow_rc_src <= cyc[3];
    hist <= {hist[0], lo_ext ? ext_slow_crystal_src : int_slow_rc_src};
    if (mon) begin
      chk({31'h0, wdt_clk}, {31'h0, hist[1]});
      chk({31'h0, tb_clk}, {31'h0, hist[1]});
    end
    // shortest legal level is two cycles, so anything shorter is a runt
    if (sys_clk !== last_clk) begin
      if (mon) chk({31'h0, run >= 2}, 32'h1);
      run <= 1;
      last_clk <= sys_clk;
    end else begin
      run <= run + 1;
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_done, w_done;
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    tmo(k, 100);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_done;
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_done = 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (!ar_done && arready) begin
        ar_done = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    tmo(k, 100);
  endtask

  task automatic do_reset(input logic [4:0] c);
    mon <= 1'b0;
    aresetn <= 1'b0;
    cfg_in <= scss_cfg_t'(c);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {mon, lo_ext} = 2'h0;
    errors = 0;
    n_checks = 0;
    aresetn = 1'b0;
    cfg_in = '0;
    for (t = 0; t < 5; t++) begin
      lo_ext = exp_cfg[t][2];
      do_reset(cfg_tab[t]);
      rd(MODE_OFS, d, r);
      chk(d, 32'h1);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd(CONFIG_OFS, d, r);
      chk(d, exp_cfg[t]);
      chk({30'h0, int_fast_rc_src_trim}, {30'h0, trim[t]});
      chk({30'h0, osc_pin_a_en, osc_pin_b_en}, {30'h0, pins[t]});
      // straps cannot be overridden from software
      wr(CONFIG_OFS, 32'h0, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(CONFIG_OFS, d, r);
      chk(d, exp_cfg[t]);
      rd(8'h0c, d, r);
      chk({d[29:0], r}, {30'h0, RESP_SLVERR});
      repeat (20) @(posedge aclk);
      mon <= 1'b1;
      for (m = 0; m < 9; m++) begin
        hl = (m == 8);
        cks = hl ? 3'h0 : m[2:0];
        wr(MODE_OFS, {28'h0, cks, hl}, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        rd(MODE_OFS, d, r);
        chk(d, {28'h0, cks, hl});
        esel = hl ? SEL_FAST : (cks < 2 ? SEL_SLOW : 3'(4'h9 - {1'b0, cks}));
        for (i = 0; i < 300; i++) begin
          rd(STATUS_OFS, d, r);
          if (d[3:1] === esel && d[0] === 1'b0) break;
        end
        tmo(i, 300);
        chk({28'h0, d[3:0]}, {28'h0, esel, 1'b0});
        per = hl ? pf[t] : (cks < 2 ? ps[t] : pf[t] << (8 - cks));
        cnt = 0;
        repeat (512) begin
          @(posedge aclk);
          if (sys_clk === 1'b1 && last_clk === 1'b0) cnt++;
        end
        chk({31'h0, (cnt + 1 >= 512 / per) && (cnt <= 512 / per + 1)}, 32'h1);
      end
      $display("config %0d done at %0t", t, $time);
    end
    finish_test();
  end
endmodule
`default_nettype wire
